// File: hdl/lcdfc_params.svh
// Register offsets, field positions and reset values of the LCD frame control block.
`ifndef LCDFC_PARAMS_SVH
`define LCDFC_PARAMS_SVH
`define LCDFC_CRA_ADDR      8'h00E4
`define LCDFC_CCR_ADDR      8'h00E7
`define LCDFC_DMEM_BASE     8'h00EC
`define LCDFC_BIT_EN        7
`define LCDFC_BIT_AB        6
`define LCDFC_BIT_IF        4
`define LCDFC_BIT_IE        3
`define LCDFC_BIT_BL        0
`define LCDFC_CRA_WMASK     8'h00C9
`define LCDFC_CRA_RSVD      8'h0026
`define LCDFC_RESET_BYTE    8'h00
`endif

// File: hdl/lcdfc_pkg.sv
// Types shared by the LCD frame control block.
package lcdfc_pkg;
    typedef enum logic [1:0] {
        LCDFC_OFF   = 2'b00,
        LCDFC_SHOW  = 2'b01,
        LCDFC_BLANK = 2'b10
    } lcdfc_state_t;
endpackage : lcdfc_pkg

// File: hdl/lcdfc_latch_if.sv
// Interface carrying the frame-latch strobe and latched data between block modules.
`timescale 1ns/1ps
interface lcdfc_latch_if #(parameter int W = 8);
    logic         load;
    logic [W-1:0] d;
    logic [W-1:0] q;
    modport ctrl (output load, output d, input q);
    modport store (input load, input d, output q);
endinterface : lcdfc_latch_if

// File: hdl/lcdfc_shadow.sv
// Shadow register that captures a word when the frame latch strobe fires.
`timescale 1ns/1ps
`include "lcdfc_params.svh"
module lcdfc_shadow (
    // Clock and reset.
    input  wire logic    clk_sys,
    input  wire logic    arst_n,
    // Latch port.
    lcdfc_latch_if.store lp
);
    logic [$bits(lp.q)-1:0] q_q;
    logic [$bits(lp.q)-1:0] q_d;

    // Next value: take the live word on a latch strobe, else hold.
    always_comb begin
        q_d = lp.load ? lp.d : q_q;
    end

    // Register the working copy.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign lp.q = q_q;
endmodule : lcdfc_shadow

// File: hdl/lcdfc_top.sv
// LCD frame control and status: control register, frame latching, flag, blanking and enable.
`timescale 1ns/1ps
`include "lcdfc_params.svh"
module lcdfc_top #(
    parameter int DMEM_REGS = 20,
    parameter int NCOM      = 4
) (
    // Clock and reset.
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    // Processor register port.
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    // Processor interrupt handshake.
    input  wire logic                  global_irq_en,
    input  wire logic                  irq_vector_ack,
    output logic                       frame_irq,
    // Timing logic.
    input  wire logic                  frame_start,
    input  wire logic [1:0]            com_index,
    // Latched settings and live pin controls toward the waveform generator.
    output logic [DMEM_REGS*8-1:0]     seg_data,
    output logic [7:0]                 contrast_latched,
    output logic                       wave_low_power,
    output logic                       pins_grounded,
    output logic                       lcd_pins_owned,
    output logic [NCOM-1:0]            com_active
);
    logic [7:0]               cra_q, cra_d;
    logic [7:0]               ccr_q, ccr_d;
    logic [DMEM_REGS*8-1:0]   dmem_q, dmem_d;
    logic                     odd_q, odd_d;
    logic                     lp_prev_q, lp_prev_d;
    lcdfc_pkg::lcdfc_state_t  st_q, st_d;
    logic                     latch_ev;
    logic                     flag_wr_clr;
    logic [7:0]               rd_d, rd_q;

    lcdfc_latch_if #(.W(DMEM_REGS*8 + 10)) lif ();

    // Live register file: writes are never blocked, whatever the frame state.
    always_comb begin
        cra_d  = cra_q;
        ccr_d  = ccr_q;
        dmem_d = dmem_q;
        flag_wr_clr = 1'b0;
        if (reg_wr) begin
            if (reg_addr == `LCDFC_CRA_ADDR) begin
                cra_d = (reg_wdata & `LCDFC_CRA_WMASK) | (cra_q & ~`LCDFC_CRA_WMASK);
                flag_wr_clr = reg_wdata[`LCDFC_BIT_IF];
            end else if (reg_addr == `LCDFC_CCR_ADDR) begin
                ccr_d = reg_wdata;
            end else begin
                for (int i = 0; i < DMEM_REGS; i++) begin
                    if (reg_addr == 8'(`LCDFC_DMEM_BASE + i)) begin
                        dmem_d[i*8 +: 8] = reg_wdata;
                    end
                end
            end
        end
        if (flag_wr_clr || irq_vector_ack) begin
            cra_d[`LCDFC_BIT_IF] = 1'b0;
        end
        if (latch_ev) begin
            cra_d[`LCDFC_BIT_IF] = 1'b1;
        end
    end

    // Frame parity: remembers whether the last frame start latched, so that in low-power
    // mode the frame after a latch repeats the same data and the DC component cancels.
    always_comb begin
        odd_d = odd_q;
        if (!cra_q[`LCDFC_BIT_EN]) begin
            odd_d = 1'b0;
        end else if (frame_start) begin
            odd_d = latch_ev;
        end
    end

    // Assertion helper: records whether the previous frame start while enabled latched.
    always_comb begin
        lp_prev_d = lp_prev_q;
        if (!cra_q[`LCDFC_BIT_EN]) begin
            lp_prev_d = 1'b0;
        end else if (frame_start) begin
            lp_prev_d = lif.load;
        end
    end

    // low power flags every second frame
    // low power latches every second frame
    assign latch_ev = frame_start && cra_q[`LCDFC_BIT_EN] && !(lif.q[0] && odd_q);

    assign lif.load = latch_ev;
    assign lif.d    = {dmem_q, ccr_q, cra_q[`LCDFC_BIT_BL], cra_q[`LCDFC_BIT_AB]};

    lcdfc_shadow u_shadow (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .lp      (lif.store)
    );

    // Drive state: off, showing, or blanked after a finished frame.
    always_comb begin
        st_d = st_q;
        case (st_q)
            lcdfc_pkg::LCDFC_OFF: begin
                if (cra_q[`LCDFC_BIT_EN]) begin
                    st_d = lcdfc_pkg::LCDFC_SHOW;
                end
            end
            lcdfc_pkg::LCDFC_SHOW: begin
                if (latch_ev && cra_q[`LCDFC_BIT_BL]) begin
                    st_d = lcdfc_pkg::LCDFC_BLANK;
                end
            end
            lcdfc_pkg::LCDFC_BLANK: begin
                if (latch_ev && !cra_q[`LCDFC_BIT_BL]) begin
                    st_d = lcdfc_pkg::LCDFC_SHOW;
                end
            end
            default: st_d = lcdfc_pkg::LCDFC_OFF;
        endcase
        if (!cra_q[`LCDFC_BIT_EN]) begin
            st_d = lcdfc_pkg::LCDFC_OFF;
        end
    end

    // Read mux, registered so read data come from a flip-flop.
    always_comb begin
        rd_d = 8'h00;
        if (reg_addr == `LCDFC_CRA_ADDR) begin
            rd_d = cra_q & (`LCDFC_CRA_WMASK | (8'h01 << `LCDFC_BIT_IF));
        end else if (reg_addr == `LCDFC_CCR_ADDR) begin
            rd_d = ccr_q;
        end else begin
            for (int i = 0; i < DMEM_REGS; i++) begin
                if (reg_addr == 8'(`LCDFC_DMEM_BASE + i)) begin
                    rd_d = dmem_q[i*8 +: 8];
                end
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cra_q  <= `LCDFC_RESET_BYTE;
            ccr_q  <= `LCDFC_RESET_BYTE;
            dmem_q <= '0;
            odd_q  <= 1'b0;
            lp_prev_q <= 1'b0;
            st_q   <= lcdfc_pkg::LCDFC_OFF;
            rd_q   <= `LCDFC_RESET_BYTE;
        end else begin
            cra_q  <= cra_d;
            ccr_q  <= ccr_d;
            dmem_q <= dmem_d;
            odd_q  <= odd_d;
            lp_prev_q <= lp_prev_d;
            st_q   <= st_d;
            rd_q   <= rd_d;
        end
    end

    // Outputs toward the processor and the analog waveform side.
    assign reg_rdata = rd_q;
    assign frame_irq = cra_q[`LCDFC_BIT_IF] && cra_q[`LCDFC_BIT_IE] && global_irq_en;
    assign seg_data         = lif.q[DMEM_REGS*8+9 : 10];
    assign contrast_latched = lif.q[9:2];
    assign wave_low_power   = lif.q[0];
    assign pins_grounded    = cra_q[`LCDFC_BIT_EN] && (st_q == lcdfc_pkg::LCDFC_BLANK);
    assign lcd_pins_owned   = cra_q[`LCDFC_BIT_EN];

    // one common addressed at a time in sequence
    // Gated by the live enable bit so that commons stop in the cycle the bit clears.
    always_comb begin
        com_active = '0;
        if (cra_q[`LCDFC_BIT_EN] && (st_q == lcdfc_pkg::LCDFC_SHOW)) begin
            com_active[com_index] = 1'b1;
        end
    end

    // Checks next to the logic.
    // flag on latch
    a_flag_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
        latch_ev |=> cra_q[`LCDFC_BIT_IF]) else $error("flag not set at frame start");
    a_wr_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (reg_wr && reg_addr == `LCDFC_CRA_ADDR && reg_wdata[`LCDFC_BIT_IF] && !latch_ev)
        |=> !cra_q[`LCDFC_BIT_IF]) else $error("write one did not clear flag");
    a_wr_zero_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (reg_wr && reg_addr == `LCDFC_CRA_ADDR && !reg_wdata[`LCDFC_BIT_IF] && !irq_vector_ack
        && cra_q[`LCDFC_BIT_IF]) |=> cra_q[`LCDFC_BIT_IF]) else $error("write zero cleared flag");
    a_ack_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (irq_vector_ack && !latch_ev) |=> !cra_q[`LCDFC_BIT_IF]) else $error("vector left flag");
    a_irq_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_irq == (cra_q[`LCDFC_BIT_IF] && cra_q[`LCDFC_BIT_IE] && global_irq_en))
        else $error("irq gating wrong");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(reg_addr) == `LCDFC_CRA_ADDR) |-> ((rd_q & `LCDFC_CRA_RSVD) == 8'h00))
        else $error("reserved bit read one");
    a_off_at_once: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !cra_q[`LCDFC_BIT_EN] |=> st_q == lcdfc_pkg::LCDFC_OFF) else $error("disable delayed");
    a_wave_held: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !latch_ev |=> $stable(wave_low_power)) else $error("waveform changed mid frame");
    // A frame start in low-power mode that follows a frame start which latched.
    sequence s_lp_repeat;
        frame_start && lp_prev_q && wave_low_power;
    endsequence
    a_lp_alternate: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_lp_repeat |-> !latch_ev) else $error("low power latched twice in a row");
endmodule : lcdfc_top

// File: tb/lcdfc_glass_model.sv
// Timing side partner: frame strobes and common stepping seen by the glass.
`timescale 1ns/1ps
module lcdfc_glass_model #(
    parameter int PERIOD = 40
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Driver running from the block.
    input  wire logic       run,
    // Strobes toward the block.
    output logic            frame_start,
    output logic [1:0]      com_index
);
    int cnt_q;

    // Commons in sequence.
    // Counts out a frame and steps the common index through it while running.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 0;
            frame_start <= 1'b0;
            com_index <= 2'h0;
        end else begin
            cnt_q <= (run && cnt_q < PERIOD - 1) ? cnt_q + 1 : 0;
            frame_start <= run && (cnt_q == PERIOD - 1);
            com_index <= 2'((cnt_q * 4) / PERIOD);
        end
    end
endmodule : lcdfc_glass_model

// File: tb/tb.sv
// Self-checking bench of the LCD frame control block.
`timescale 1ns/1ps
`include "lcdfc_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    logic         clk_sys, arst_n, reg_wr, global_irq_en, irq_vector_ack;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, contrast_latched, r, v, c;
    logic         frame_irq, frame_start, wave_low_power, pins_grounded, lcd_pins_owned;
    logic [1:0]   com_index;
    logic [159:0] seg_data;
    logic [3:0]   com_active;
    int           fail_count, n_checks, hits;

    lcdfc_top dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
        .irq_vector_ack(irq_vector_ack), .frame_irq(frame_irq), .frame_start(frame_start),
        .com_index(com_index), .seg_data(seg_data), .contrast_latched(contrast_latched),
        .wave_low_power(wave_low_power), .pins_grounded(pins_grounded),
        .lcd_pins_owned(lcd_pins_owned), .com_active(com_active));
    lcdfc_glass_model glass_u (.clk_sys(clk_sys), .arst_n(arst_n), .run(lcd_pins_owned),
        .frame_start(frame_start), .com_index(com_index));

    // Expected read value of the control register after a write and a flag state.
    function automatic logic [7:0] cra_exp(input logic [7:0] w, input logic f);
        return (w & `LCDFC_CRA_WMASK) | {3'h0, f, 4'h0};
    endfunction : cra_exp

    // Clock generation.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // One write strobe on a falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    // Present an address and take the registered data one cycle later.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd

    // Wait for the edge that takes a frame strobe, then let it settle.
    task automatic wait_frame;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_sys);
            if (frame_start === 1'b1) break;
            if (i == 199) fail_count++;
        end
        @(negedge clk_sys);
    endtask : wait_frame

    // Verdict and end of run.
    task automatic finish_test;
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // Watchdog against a hang.
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end

    // Main sequence.
    initial begin
        {arst_n, reg_wr, global_irq_en, irq_vector_ack} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        void'($urandom(32'hc1b4));
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        rd(`LCDFC_CRA_ADDR, r);
        `CHK("cra_reset", 8'h00, r)
        rd(8'h10, r);
        `CHK("unmapped", 8'h00, r)
        wr(`LCDFC_CRA_ADDR, 8'hee);
        rd(`LCDFC_CRA_ADDR, r);
        `CHK("cra_rsvd", cra_exp(8'hee, 0), r)
        // Disable before reprogramming; commons drop in the same cycle.
        wr(`LCDFC_CRA_ADDR, 8'h00);
        `CHK("off_com", 4'h0, com_active)
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            c = 8'(`LCDFC_DMEM_BASE + $urandom_range(19));
            wr(c, v);
            rd(c, r);
            `CHK("dmem_rd", v, r)
        end
        // Memory and contrast set up before enabling.
        v = 8'($urandom);
        c = 8'($urandom);
        wr(`LCDFC_DMEM_BASE, v);
        wr(`LCDFC_CCR_ADDR, c);
        global_irq_en = 1'b1;
        wr(`LCDFC_CRA_ADDR, 8'h88);
        `CHK("owned", 1'b1, lcd_pins_owned)
        `CHK("no_early_latch", 8'h00, seg_data[7:0])
        `CHK("no_early_ccr", 8'h00, contrast_latched)
        wait_frame();
        `CHK("seg_latch", v, seg_data[7:0])
        `CHK("ccr_latch", c, contrast_latched)
        `CHK("irq", 1'b1, frame_irq)
        `CHK("one_com", 1, $countones(com_active))
        wr(`LCDFC_CRA_ADDR, 8'h88);
        rd(`LCDFC_CRA_ADDR, r);
        `CHK("keep_flag", cra_exp(8'h88, 1), r)
        wr(`LCDFC_CRA_ADDR, 8'h98);
        rd(`LCDFC_CRA_ADDR, r);
        `CHK("clr_flag", cra_exp(8'h88, 0), r)
        wait_frame();
        global_irq_en = 1'b0;
        @(negedge clk_sys);
        `CHK("irq_gated", 1'b0, frame_irq)
        global_irq_en = 1'b1;
        irq_vector_ack = 1'b1;
        @(negedge clk_sys);
        irq_vector_ack = 1'b0;
        @(negedge clk_sys);
        `CHK("ack_clr", 1'b0, frame_irq)
        wr(`LCDFC_CRA_ADDR, 8'hc8);
        `CHK("lp_wait", 1'b0, wave_low_power)
        hits = 0;
        for (int i = 0; i < 4; i++) begin
            wait_frame();
            if (frame_irq === 1'b1) begin
                hits++;
                wr(`LCDFC_CRA_ADDR, 8'hd8);
            end
        end
        `CHK("lp_flags", 2, hits)
        `CHK("lp_on", 1'b1, wave_low_power)
        // Wait for a flagged frame, blank while clearing the flag, then wait two frames.
        wait_frame();
        `CHK("pre_blank_flag", 1'b1, frame_irq)
        wr(`LCDFC_CRA_ADDR, 8'h99);
        `CHK("blank_wait", 1'b0, pins_grounded)
        wait_frame();
        wait_frame();
        `CHK("blanked", 1'b1, pins_grounded)
        `CHK("blank_flag", 1'b1, frame_irq)
        `CHK("lp_off", 1'b0, wave_low_power)
        // Disable last; the block leaves every port pin undriven.
        wr(`LCDFC_CRA_ADDR, 8'h00);
        `CHK("released", 1'b0, lcd_pins_owned)
        `CHK("no_com", 4'h0, com_active)
        `CHK("no_ground", 1'b0, pins_grounded)
        finish_test();
    end
endmodule : tb
